//--- cfb_core.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - minus_one subtracts one and writes the result back to the operand.
// - minus_one: zero flag when original is 1; carry clear only when original is 0.
// - minus_one: overflow only when original is the most negative value.
// - minus_two subtracts two; zero when original 2; carry clear for 0 or 1.
// - minus_two: overflow when original is most negative or one above it.
// - the five arithmetic forms set the sign flag from the result's top bit.
// - arithmetic forms leave both halt bits and the interrupt allow bit alone.
// - irq_mask_all clears only the interrupt allow bit of the status word.
// - irq_unmask_all sets only the interrupt allow bit of the status word.
// - after unmask the next instruction runs before any interrupt is granted.
// - plus_one adds one; zero and carry set only when original is all ones.
// - plus_one: overflow only when original is the largest positive value.
// - plus_two adds two; zero flag when original is all ones minus one.
// - plus_two: carry when original is all ones or all ones minus one.
// - plus_two: overflow when original is the largest positive or one below.
// - bitwise_not inverts the operand; zero flag when original is all ones.
// - bitwise_not: carry is the inverse of the zero condition of the result.
// - bitwise_not: overflow when the original operand was negative.
// - branch_on_carry adds twice the signed offset to PC when carry set.
// - branch_on_equal adds twice the signed offset to PC when zero set.
// - branches and mask operations leave the four arithmetic flags alone.
module cfb_core
   import cfb_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Core side
   input  wire logic                irq_pending,
   output logic                     irq_grant,
   output cfb_flag_word_t           flag_word,
   output logic      [15:0]         prog_counter,
   output logic      [15:0]         result
);

   logic [31:0]    prdata_q;
   logic           pready_q;
   logic           pslverr_q;
   logic           irq_grant_q;
   cfb_flag_word_t flags_q;
   cfb_flag_word_t flags_d;
   logic [15:0]    pc_q;
   logic [15:0]    pc_d;
   logic [15:0]    result_q;
   logic [15:0]    operand_q;
   cfb_instr_t     instr_q;
   logic           irq_hold_q;
   logic           illegal_q;

   logic           access;
   logic           wr_en;
   logic           mapped;
   logic           exec;
   logic           legal;
   logic           arith;
   cfb_instr_t     instr_w;
   logic [15:0]    dst;
   logic [15:0]    res;
   logic [15:0]    all_v;
   logic [15:0]    min_v;
   logic [15:0]    max_v;
   logic           c_n;
   logic           z_n;
   logic           v_n;
   logic [15:0]    branch_ofs;

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign irq_grant    = irq_grant_q;
   assign flag_word    = flags_q;
   assign prog_counter = pc_q;
   assign result       = result_q;

   // One wait state so that every bus answer is registered
   assign access = psel && penable && !pready_q;
   assign wr_en  = psel && penable && pready_q && pwrite && !pslverr_q;

   // Unmapped offsets still answer, with an error, so the bus never hangs
   always_comb
   begin
      if (paddr == ADDR_W'(ADDR_CTRL))
         mapped = 1'b1;
      else if (paddr == ADDR_W'(ADDR_OPERAND))
         mapped = 1'b1;
      else if (paddr == ADDR_W'(ADDR_RESULT))
         mapped = 1'b1;
      else if (paddr == ADDR_W'(ADDR_FLAGS))
         mapped = 1'b1;
      else if (paddr == ADDR_W'(ADDR_PC))
         mapped = 1'b1;
      else if (paddr == ADDR_W'(ADDR_STATUS))
         mapped = 1'b1;
      else
         mapped = 1'b0;
   end

   assign instr_w = cfb_instr_t'({pwdata[OFS_LSB +: OFS_W], pwdata[BYTE_BIT],
                                  pwdata[OP_LSB +: OP_W]});
   // Opcodes past the last branch are refused and only flagged
   assign exec    = wr_en && (paddr == ADDR_W'(ADDR_CTRL));
   assign legal   = (instr_w.op <= OP_BR_EQUAL);
   assign arith   = (instr_w.op >= OP_MINUS_ONE) && (instr_w.op <= OP_NOT);

   // Byte form sees only the low eight bits
   always_comb
   begin
      if (instr_w.byte_mode)
      begin
         dst   = operand_q & ALL_B;
         all_v = ALL_B;
         min_v = MIN_B;
         max_v = MAX_B;
      end
      else
      begin
         dst   = operand_q;
         all_v = ALL_W;
         min_v = MIN_W;
         max_v = MAX_W;
      end
   end

   always_comb
   begin
      res = dst;
      c_n = 1'b0;
      z_n = 1'b0;
      v_n = 1'b0;
      case (instr_w.op)
         OP_MINUS_ONE:
         begin
            res = (dst - VAL_ONE) & all_v;
            z_n = (dst == VAL_ONE);
            c_n = (dst != 16'h0000);
            v_n = (dst == min_v);
         end
         OP_MINUS_TWO:
         begin
            res = (dst - VAL_TWO) & all_v;
            z_n = (dst == VAL_TWO);
            c_n = (dst > VAL_ONE);
            v_n = (dst == min_v) || (dst == (min_v + VAL_ONE));
         end
         OP_PLUS_ONE:
         begin
            res = (dst + VAL_ONE) & all_v;
            z_n = (dst == all_v);
            c_n = (dst == all_v);
            v_n = (dst == max_v);
         end
         OP_PLUS_TWO:
         begin
            res = (dst + VAL_TWO) & all_v;
            z_n = (dst == (all_v - VAL_ONE));
            c_n = (dst == (all_v - VAL_ONE)) || (dst == all_v);
            v_n = (dst == max_v) || (dst == (max_v - VAL_ONE));
         end
         OP_NOT:
         begin
            res = dst ^ all_v;
            z_n = (dst == all_v);
            c_n = ((dst ^ all_v) != 16'h0000);
            v_n = instr_w.byte_mode ? dst[SIGN_B] : dst[SIGN_W];
         end
         default:
         begin
            // Other ops pass the operand through untouched
            res = dst;
         end
      endcase
   end

   // Status word next value; halt bits are never touched here
   always_comb
   begin
      flags_d = flags_q;
      case (instr_w.op)
         OP_IRQ_MASK:
            flags_d = cfb_flag_word_t'(flags_q & ~GIE_MASK);
         OP_IRQ_UNMASK:
            flags_d = cfb_flag_word_t'(flags_q | GIE_MASK);
         default:
         begin
            if (arith)
            begin
               flags_d.msb_flag       = instr_w.byte_mode ? res[SIGN_B] : res[SIGN_W];
               flags_d.all_clear_flag = z_n;
               flags_d.bit_out_flag   = c_n;
               flags_d.sum_range_flag = v_n;
            end
         end
      endcase
   end

   // Offset counts words, so it is doubled into bytes
   assign branch_ofs = {{(16-OFS_W-1){instr_w.offset[OFS_W-1]}}, instr_w.offset, 1'b0};

   always_comb
   begin
      // Illegal ops never load this, so the PC waits with them
      pc_d = pc_q + INSTR_LEN;
      if ((instr_w.op == OP_BR_CARRY) && flags_q.bit_out_flag)
         pc_d = pc_q + INSTR_LEN + branch_ofs;
      else if ((instr_w.op == OP_BR_EQUAL) && flags_q.all_clear_flag)
         pc_d = pc_q + INSTR_LEN + branch_ofs;
   end

   // APB answer
   // Registered answer costs a cycle but keeps decode off the outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else
      begin
         pready_q  <= access;
         pslverr_q <= access && !mapped;
         if (access && !pwrite)
         begin
            if (paddr == ADDR_W'(ADDR_CTRL))
               prdata_q <= 32'({instr_q.offset, 11'h000, instr_q.byte_mode,
                                instr_q.op});
            else if (paddr == ADDR_W'(ADDR_OPERAND))
               prdata_q <= 32'(operand_q);
            else if (paddr == ADDR_W'(ADDR_RESULT))
               prdata_q <= 32'(result_q);
            else if (paddr == ADDR_W'(ADDR_FLAGS))
               prdata_q <= 32'(flags_q);
            else if (paddr == ADDR_W'(ADDR_PC))
               prdata_q <= 32'(pc_q);
            else if (paddr == ADDR_W'(ADDR_STATUS))
               // Grant, unmask hold, sticky illegal
               prdata_q <= 32'({irq_grant_q, irq_hold_q, illegal_q});
            else
               prdata_q <= 32'h0000_0000;
         end
         else
         begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // Instruction register and operand write-back
   // Byte form writes back a cleared high byte
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         instr_q   <= '0;
         operand_q <= 16'h0000;
         result_q  <= 16'h0000;
      end
      else if (exec && legal)
      begin
         instr_q <= instr_w;
         if (arith)
         begin
            operand_q <= res;
            result_q  <= res;
         end
      end
      else if (wr_en && (paddr == ADDR_W'(ADDR_OPERAND)))
      begin
         operand_q <= pwdata[15:0];
      end
   end

   // Status word and program counter
   // Direct writes never meet an execute: one address per transfer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_q <= cfb_flag_word_t'(FLAGS_RESET);
         pc_q    <= 16'h0000;
      end
      else if (exec && legal)
      begin
         flags_q <= flags_d;
         pc_q    <= pc_d;
      end
      else if (wr_en && (paddr == ADDR_W'(ADDR_FLAGS)))
      begin
         flags_q       <= cfb_flag_word_t'(pwdata[8:0]);
         flags_q.spare <= 2'b00;
      end
      else if (wr_en && (paddr == ADDR_W'(ADDR_PC)))
      begin
         pc_q <= pwdata[15:0] & ~VAL_ONE;
      end
   end

   // Illegal opcode is sticky; a new one beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         illegal_q <= 1'b0;
      else if (exec && !legal)
         illegal_q <= 1'b1;
      else if (wr_en && (paddr == ADDR_W'(ADDR_STATUS)) && pwdata[STAT_ILLEGAL])
         illegal_q <= 1'b0;
   end

   // Hold keeps a pending request off until one more instruction has run
   // Interrupt window: grant uses the allow bit as it stood before this edge,
   // so one interrupt may still slip in right after a mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_hold_q  <= 1'b0;
         irq_grant_q <= 1'b0;
      end
      else
      begin
         if (exec && legal)
            irq_hold_q <= (instr_w.op == OP_IRQ_UNMASK);
         irq_grant_q <= flags_q.global_irq_allow && irq_pending && !irq_hold_q;
      end
   end

endmodule // cfb_core

//--- cfb_core_sva.sv
`timescale 1ns/1ps
module cfb_core_sva
   import cfb_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // Bus
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   // Core side
   input wire logic              irq_grant,
   input wire cfb_flag_word_t    flag_word,
   input wire logic [15:0]       prog_counter,
   input wire logic [15:0]       result
);
   logic        ex;
   logic [3:0]  op;
   logic [8:0]  fw;
   logic [15:0] tgt;
   logic [15:0] pc_c;
   logic [15:0] pc_z;
   assign ex   = psel && penable && pready && pwrite && paddr == ADDR_W'(ADDR_CTRL);
   assign op   = pwdata[3:0];
   assign fw   = flag_word;
   assign tgt  = prog_counter + 16'h0002 + {{5{pwdata[25]}}, pwdata[25:16], 1'b0};
   assign pc_c = fw[0] ? tgt : prog_counter + 16'h0002;
   assign pc_z = fw[1] ? tgt : prog_counter + 16'h0002;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_mask;
      ex && op == OP_IRQ_MASK |=> !fw[3];
   endproperty
   a_mask: assert property (p_mask) else $error("allow bit kept");
   property p_unmask;
      ex && op == OP_IRQ_UNMASK |=> fw[3];
   endproperty
   a_unmask: assert property (p_unmask) else $error("allow bit not set");
   property p_keep_mode;
      ex && op inside {[OP_MINUS_ONE:OP_NOT]} |=> $stable(fw[5:3]);
   endproperty
   a_keep_mode: assert property (p_keep_mode) else $error("mode bits moved");
   property p_keep_flags;
      ex && op inside {[OP_IRQ_MASK:OP_BR_EQUAL]} |=> $stable({fw[8], fw[2:0]});
   endproperty
   a_keep_flags: assert property (p_keep_flags) else $error("flags moved");
   property p_sign;
      ex && op inside {[OP_MINUS_ONE:OP_NOT]}
         |=> fw[2] == result[$past(pwdata[BYTE_BIT]) ? SIGN_B : SIGN_W];
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag wrong");
   property p_hold;
      ex && op == OP_IRQ_UNMASK |=> ##1 !irq_grant;
   endproperty
   a_hold: assert property (p_hold) else $error("grant right after unmask");
   property p_br_carry;
      ex && op == OP_BR_CARRY |=> prog_counter == $past(pc_c);
   endproperty
   a_br_carry: assert property (p_br_carry) else $error("carry branch pc");
   property p_br_equal;
      ex && op == OP_BR_EQUAL |=> prog_counter == $past(pc_z);
   endproperty
   a_br_equal: assert property (p_br_equal) else $error("equal branch pc");
   c_unmask: cover property (ex && op == OP_IRQ_UNMASK);
   c_taken: cover property (ex && op == OP_BR_CARRY && fw[0]);
   c_grant: cover property ($rose(irq_grant));
endmodule // cfb_core_sva

bind cfb_core cfb_core_sva #(.ADDR_W(ADDR_W)) cfb_core_sva_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .irq_grant(irq_grant),
   .flag_word(flag_word), .prog_counter(prog_counter), .result(result));

//--- cfb_pkg.sv
package cfb_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_OPERAND = 8'h04;
   localparam logic [7:0] ADDR_RESULT  = 8'h08;
   localparam logic [7:0] ADDR_FLAGS   = 8'h0C;
   localparam logic [7:0] ADDR_PC      = 8'h10;
   localparam logic [7:0] ADDR_STATUS  = 8'h14;

   // Instruction word fields in CTRL
   localparam int OP_LSB   = 0;
   localparam int OP_W     = 4;
   localparam int BYTE_BIT = 4;
   localparam int OFS_LSB  = 16;
   localparam int OFS_W    = 10;

   // Operation codes
   localparam logic [3:0] OP_IDLE        = 4'h0;
   localparam logic [3:0] OP_MINUS_ONE   = 4'h1;
   localparam logic [3:0] OP_MINUS_TWO   = 4'h2;
   localparam logic [3:0] OP_PLUS_ONE    = 4'h3;
   localparam logic [3:0] OP_PLUS_TWO    = 4'h4;
   localparam logic [3:0] OP_NOT         = 4'h5;
   localparam logic [3:0] OP_IRQ_MASK    = 4'h6;
   localparam logic [3:0] OP_IRQ_UNMASK  = 4'h7;
   localparam logic [3:0] OP_BR_CARRY    = 4'h8;
   localparam logic [3:0] OP_BR_EQUAL    = 4'h9;

   // Operand constants
   localparam logic [15:0] VAL_ONE   = 16'h0001;
   localparam logic [15:0] VAL_TWO   = 16'h0002;
   localparam logic [15:0] ALL_W     = 16'hFFFF;
   localparam logic [15:0] ALL_B     = 16'h00FF;
   localparam logic [15:0] MIN_W     = 16'h8000;
   localparam logic [15:0] MIN_B     = 16'h0080;
   localparam logic [15:0] MAX_W     = 16'h7FFF;
   localparam logic [15:0] MAX_B     = 16'h007F;
   localparam int          SIGN_W    = 15;
   localparam int          SIGN_B    = 7;
   localparam logic [15:0] INSTR_LEN = 16'h0002;

   // Status word layout and masks
   localparam logic [8:0] GIE_MASK    = 9'h008;
   localparam logic [8:0] FLAGS_RESET = 9'h000;
   localparam int         STAT_ILLEGAL = 0;
   localparam int         STAT_HOLD    = 1;
   localparam int         STAT_GRANT   = 2;

   typedef struct packed {
      logic       sum_range_flag;
      logic [1:0] spare;
      logic       halt_oscillator;
      logic       halt_core;
      logic       global_irq_allow;
      logic       msb_flag;
      logic       all_clear_flag;
      logic       bit_out_flag;
   } cfb_flag_word_t;

   typedef struct packed {
      logic [9:0] offset;
      logic       byte_mode;
      logic [3:0] op;
   } cfb_instr_t;

endpackage

//--- test_cfb_core.sv
`timescale 1ns/1ps
module test_cfb_core
   import cfb_pkg::*;
;
   logic           pclk, presetn, psel, penable, pwrite, irq_pending;
   logic           pready, pslverr, irq_grant, err;
   logic [7:0]     paddr;
   logic [31:0]    pwdata, prdata, rd, seed;
   logic [15:0]    result, prog_counter, pc;
   cfb_flag_word_t flag_word;
   logic [8:0]     f, e;
   logic [9:0]     o;
   int             bad_count, n_checks, r, v, s;
   int             vals[$] = '{0, 1, 2, 'h7E, 'h7F, 'h80, 'h81, 'hFE, 'hFF,
                               'h7FFE, 'h7FFF, 'h8000, 'h8001, 'hFFFE, 'hFFFF};
   int             ofs[$] = '{0, 1, 'h1FF, 'h200, 'h3FF};

   cfb_core cfb_core_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_pending(irq_pending), .irq_grant(irq_grant),
      .flag_word(flag_word), .prog_counter(prog_counter), .result(result));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Flags expected from the original operand; r gets the result
   function automatic logic [8:0] mdl(input int op, b, v, input logic [8:0] fi,
                                      output int r);
      int m, s, c, ov;
      m = b ? 'hFF : 'hFFFF;
      s = b ? 'h80 : 'h8000;
      v = v & m;
      r = op == 1 ? v - 1 : op == 2 ? v - 2 : op == 3 ? v + 1 : op == 4 ? v + 2 : ~v;
      c = op < 3 ? v >= op : op < 5 ? r > m : (r & m) != 0;
      r = r & m;
      ov = op == 1 ? v == s : op == 2 ? (v >> 1) == (s >> 1) : op == 3 ? v == s - 1
         : op == 4 ? (v >> 1) == ((s - 1) >> 1) : (v & s) != 0;
      return {ov[0], 2'b0, fi[5:3], (r & s) != 0, r == 0, c[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex, g);
      n_checks++;
      if (g !== ex)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, ex, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (pready !== 1'b1 && t < 20);
      if (t >= 20)
         bad_count++;
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic ex(input int op, b, ofs);
      apb(1'b1, ADDR_CTRL, {6'h0, ofs[9:0], 11'h0, b[0], op[3:0]});
      @(negedge pclk);
   endtask

   task automatic print_verdict;
      $display("checks %0d bad %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge pclk);
      bad_count++;
      print_verdict();
   end

   initial
   begin
      {psel, penable, pwrite, irq_pending, presetn} = '0;
      paddr  = '0;
      pwdata = '0;
      seed   = 32'hCB6F;
      pc     = 16'h0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < vals.size() + 10; i++)
         for (int op = 1; op < 6; op++)
            for (int b = 0; b < 2; b++)
            begin
               seed = lfsr(seed);
               v = i < vals.size() ? vals[i] : int'(seed[15:0]);
               f = seed[24:16] & 9'h13F;
               irq_pending <= seed[31];
               apb(1'b1, ADDR_FLAGS, 32'(f));
               apb(1'b1, ADDR_OPERAND, v);
               e = mdl(op, b, v, f, r);
               ex(op, b, 0);
               pc += 16'h0002;
               chk("result", r, result);
               chk("flags", 32'(e), 32'(flag_word));
               chk("pc", pc, prog_counter);
               apb(1'b0, ADDR_OPERAND, 0);
               chk("operand", r, rd);
            end
      $display("arithmetic done");
      irq_pending <= 1'b1;
      apb(1'b1, ADDR_FLAGS, 32'h13F);
      ex(OP_IRQ_MASK, 0, 0);
      chk("flags", 32'h137, 32'(flag_word));
      ex(OP_IRQ_UNMASK, 0, 0);
      chk("flags", 32'h13F, 32'(flag_word));
      repeat (3) @(negedge pclk);
      chk("grant", 0, irq_grant);
      ex(OP_IDLE, 0, 0);
      @(negedge pclk);
      chk("grant", 1, irq_grant);
      ex(OP_IRQ_MASK, 0, 0);
      chk("grant", 1, irq_grant);
      @(negedge pclk);
      chk("grant", 0, irq_grant);
      $display("interrupt allow done");
      foreach (ofs[k])
         for (int op = 8; op < 10; op++)
            for (int t = 0; t < 2; t++)
            begin
               seed = lfsr(seed);
               s = op == 8 ? 1 : 2;
               f = (seed[24:16] & 9'h13C) | 9'(t ? s : 3 ^ s);
               o = ofs[k];
               pc = seed[31:16] & 16'hFFFE;
               apb(1'b1, ADDR_FLAGS, 32'(f));
               apb(1'b1, ADDR_PC, pc);
               ex(op, 0, ofs[k]);
               pc = pc + 16'h0002 + (t ? {{5{o[9]}}, o, 1'b0} : 16'h0000);
               chk("pc", pc, prog_counter);
               chk("flags", 32'(f), 32'(flag_word));
            end
      $display("branches done");
      apb(1'b0, 8'h3C, 0);
      chk("slverr", 1, err);
      chk("rdata", 0, rd);
      $display("unmapped done");
      apb(1'b1, ADDR_FLAGS, 0);
      apb(1'b1, ADDR_PC, 32'h0000_0100);
      ex(10, 0, 0);
      chk("pc", 32'h0000_0100, prog_counter);
      apb(1'b0, ADDR_STATUS, 0);
      chk("status", 1, rd);
      apb(1'b0, ADDR_CTRL, 0);
      chk("ctrl", {6'h0, 10'h3FF, 11'h0, 1'b0, 4'h9}, rd);
      apb(1'b1, ADDR_STATUS, 1);
      apb(1'b0, ADDR_STATUS, 0);
      chk("status", 0, rd);
      $display("status done");
      print_verdict();
   end
endmodule // test_cfb_core
